// ### pkg/cfg_image_pkg.sv
// Constants for the configuration image loader and wake request logic
package cfg_image_pkg;
	// Core clock
	localparam int CLK_PERIOD_NS = 8;
	// Wake pulse durations, in ns
	localparam int PULSE_SHORT_NS = 1500000;
	localparam int PULSE_LONG_NS = 150000000;
	localparam int PULSE_SHORT_CYC = PULSE_SHORT_NS / CLK_PERIOD_NS;
	localparam int PULSE_LONG_CYC = PULSE_LONG_NS / CLK_PERIOD_NS;
	// Image byte offsets
	localparam logic [7:0] PME_FLAGS_OFS = 8'h09;
	localparam logic [7:0] PTR_FIRST_OFS = 8'h30;
	localparam int PTR_COUNT = 24;
	localparam logic [7:0] BOS_PTR_OFS = 8'h30;
	localparam logic [7:0] SS_DEV_LEN_OFS = 8'h31;
	localparam logic [7:0] SS_CFG_LEN_OFS = 8'h33;
	localparam logic [7:0] HS_DEV_LEN_OFS = 8'h35;
	localparam logic [7:0] HS_CFG_LEN_OFS = 8'h37;
	localparam logic [7:0] FS_DEV_LEN_OFS = 8'h39;
	localparam logic [7:0] FS_CFG_LEN_OFS = 8'h3b;
	localparam logic [7:0] WF_LEN_OFS = 8'h3d;
	localparam logic [7:0] LTM_LEN_OFS = 8'h3f;
	localparam logic [7:0] TB_LEN_OFS = 8'h41;
	localparam logic [7:0] SW_LEN_OFS = 8'h46;
	// Pointer table indices of the fetched blocks (length, then offset)
	localparam int WF_LEN_IDX = 8'h3d - 8'h30;
	localparam int LTM_LEN_IDX = 8'h3f - 8'h30;
	localparam int TB_LEN_IDX = 8'h41 - 8'h30;
	// Block lengths in bytes and placement in the block store
	localparam logic [7:0] WF_LEN = 8'h14;
	localparam logic [7:0] LTM_LEN = 8'h18;
	localparam logic [7:0] TB_LEN = 8'h04;
	localparam logic [5:0] WF_BASE = 6'h00;
	localparam logic [5:0] WF_MASK_BASE = 6'h04;
	localparam logic [5:0] LTM_BASE = 6'h14;
	localparam logic [5:0] TB_BASE = 6'h2c;
	localparam int STORE_DEPTH = 48;
	localparam int BLK_COUNT = 3;
	// PME flag byte fields
	localparam int PME_EN_BIT = 7;
	localparam int PME_PULSE_BIT = 6;
	localparam int PME_LONG_BIT = 5;
	localparam int PME_POL_BIT = 4;
	localparam int PME_PP_BIT = 3;
	localparam logic [7:0] PME_FLAGS_RST = 8'h00;
	// Register map, byte addresses
	localparam logic [11:0] STATUS_ADDR = 12'h000;
	localparam logic [11:0] FLAGS_ADDR = 12'h004;
	localparam logic [11:0] CTRL_ADDR = 12'h008;
	localparam logic [3:0] PTR_PAGE = 4'h1;
	localparam logic [3:0] STORE_PAGE = 4'h2;
	// Status and control fields
	localparam int ST_DONE_BIT = 0;
	localparam int ST_ERR_BIT = 1;
	localparam int ST_WAKE_BIT = 2;
	localparam int ST_PRES_LSB = 4;
	localparam int CTRL_CLR_BIT = 0;
	localparam int CTRL_RELOAD_BIT = 1;
endpackage

// ### hdl/cfg_byte_mem.sv
// Block store for fetched image bytes, registered read port
`timescale 1ns/1ps
`default_nettype none
module cfg_byte_mem #(
	parameter int DW = 8,
	parameter int DEPTH = 48,
	parameter int AW = 6
) (
	input wire logic sys_clk,
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [DW-1:0] wdata,
	input wire logic [AW-1:0] raddr,
	output logic [DW-1:0] rdata
);
	logic [DW-1:0] mem [0:DEPTH-1];
	logic [DW-1:0] rdata_reg;

	// No reset on the array; absent blocks are masked by the reader
	always_ff @(posedge sys_clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata_reg <= mem[raddr];
	end
	assign rdata = rdata_reg;
endmodule
`default_nettype wire

// ### hdl/eeprom_config_image_pme.sv
// Configuration image loader with wake request pin control
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Filter bytes: four config, sixteen mask
// - BOS block is served as one block
// - Descriptor length and offset from paired entries
// - Software descriptor length 46h, offset 47h
// - Enable bit gates wake pin and other bits
// - Bit 6 picks level or pulse
// - Bit 5 picks 1.5 ms or 150 ms
// - Pulse timed from first event, never restarted
// - Bit 4 sets active polarity
// - Bit 3 picks open drain or push-pull
// - Offset entries count 16-bit words
// - Zero length means absent, use defaults
module eeprom_config_image_pme #(
	parameter int EE_AW = 10,
	parameter int PULSE_SHORT_CYC = cfg_image_pkg::PULSE_SHORT_CYC,
	parameter int PULSE_LONG_CYC = cfg_image_pkg::PULSE_LONG_CYC
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [11:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic ee_rd_req,
	output logic [EE_AW-1:0] ee_addr,
	input wire logic [7:0] ee_rd_data,
	input wire logic ee_rd_valid,
	input wire logic gpio_wake_event,
	input wire logic packet_event,
	input wire logic wake_frame_filter_match,
	input wire logic exact_destination_match,
	input wire logic link_change_event,
	output logic wake_request_pin_o,
	output logic wake_request_pin_oe,
	output logic config_done
);
	localparam int CW = $clog2(PULSE_LONG_CYC + 1);
	localparam logic [1:0] PH_FLAGS = 2'd0;
	localparam logic [1:0] PH_PTR = 2'd1;
	localparam logic [1:0] PH_BLK = 2'd2;

	typedef enum logic [2:0] {
		L_IDLE = 3'b000,
		L_REQ = 3'b001,
		L_WAIT = 3'b010,
		L_NEXT = 3'b011,
		L_SEL = 3'b100,
		L_DONE = 3'b101
	} load_st_t;
	typedef enum logic [1:0] {
		B_IDLE = 2'b00,
		B_DEC = 2'b01,
		B_ACK = 2'b10
	} bus_st_t;

	load_st_t ld_reg, ld_next;
	logic [1:0] phase_reg, phase_next;
	logic [5:0] idx_reg, idx_next;
	logic [1:0] blk_reg, blk_next;
	logic [7:0] ptr_reg [0:23];
	logic [7:0] ptr_next [0:23];
	logic [7:0] flags_reg, flags_next;
	logic [2:0] pres_reg, pres_next;
	logic err_reg, err_next;
	logic done_reg, done_next;
	logic ee_req_reg, ee_req_next;
	logic [EE_AW-1:0] ee_addr_reg, ee_addr_next;
	logic [7:0] b_len, b_ptr, b_exp;
	logic [5:0] b_base;
	logic mem_we;
	logic [5:0] mem_waddr, mem_raddr;
	logic [7:0] mem_rdata;
	bus_st_t bus_reg, bus_next;
	logic [31:0] rd_reg, rd_next;
	logic wait_reg, wait_next;
	logic sw_clear, sw_reload;
	logic lvl_reg, lvl_next;
	logic [CW-1:0] cnt_reg, cnt_next;
	logic pin_o_reg, pin_o_next, pin_oe_reg, pin_oe_next;
	logic ev, wake_active, pin_level;

	// Per-block length entry, word pointer, expected length and store base
	always_comb begin
		b_len = 8'h00;
		b_ptr = 8'h00;
		b_exp = 8'h00;
		b_base = 6'h00;
		case (blk_reg)
			2'd0: begin
				b_len = ptr_reg[cfg_image_pkg::WF_LEN_IDX];
				b_ptr = ptr_reg[cfg_image_pkg::WF_LEN_IDX + 1];
				b_exp = cfg_image_pkg::WF_LEN;
				b_base = cfg_image_pkg::WF_BASE;
			end
			2'd1: begin
				b_len = ptr_reg[cfg_image_pkg::LTM_LEN_IDX];
				b_ptr = ptr_reg[cfg_image_pkg::LTM_LEN_IDX + 1];
				b_exp = cfg_image_pkg::LTM_LEN;
				b_base = cfg_image_pkg::LTM_BASE;
			end
			2'd2: begin
				b_len = ptr_reg[cfg_image_pkg::TB_LEN_IDX];
				b_ptr = ptr_reg[cfg_image_pkg::TB_LEN_IDX + 1];
				b_exp = cfg_image_pkg::TB_LEN;
				b_base = cfg_image_pkg::TB_BASE;
			end
			default: begin
				b_len = 8'h00;
			end
		endcase
	end

	// Loader: flag byte, then pointer table 30h-47h, then the blocks
	always_comb begin
		ld_next = ld_reg;
		phase_next = phase_reg;
		idx_next = idx_reg;
		blk_next = blk_reg;
		ptr_next = ptr_reg;
		flags_next = flags_reg;
		pres_next = pres_reg;
		err_next = err_reg;
		done_next = done_reg;
		ee_req_next = 1'b0;
		ee_addr_next = ee_addr_reg;
		mem_we = 1'b0;
		mem_waddr = b_base + idx_reg;
		case (ld_reg)
			L_IDLE: begin
				phase_next = PH_FLAGS;
				idx_next = 6'h00;
				blk_next = 2'd0;
				pres_next = 3'b000;
				err_next = 1'b0;
				done_next = 1'b0;
				ld_next = L_REQ;
			end
			L_REQ: begin
				ee_req_next = 1'b1;
				case (phase_reg)
					PH_FLAGS: ee_addr_next = EE_AW'(cfg_image_pkg::PME_FLAGS_OFS);
					PH_PTR: ee_addr_next = EE_AW'(cfg_image_pkg::PTR_FIRST_OFS)
						+ EE_AW'(idx_reg);
					default: ee_addr_next = EE_AW'({b_ptr, 1'b0})
						+ EE_AW'(idx_reg);
				endcase
				ld_next = L_WAIT;
			end
			L_WAIT: begin
				if (ee_rd_valid) begin
					case (phase_reg)
						PH_FLAGS: flags_next = ee_rd_data;
						PH_PTR: ptr_next[idx_reg[4:0]] = ee_rd_data;
						default: mem_we = 1'b1;
					endcase
					ld_next = L_NEXT;
				end
			end
			L_NEXT: begin
				ld_next = L_REQ;
				idx_next = idx_reg + 6'h01;
				if (phase_reg == PH_FLAGS) begin
					phase_next = PH_PTR;
					idx_next = 6'h00;
				end else if (phase_reg == PH_PTR) begin
					if (idx_reg == 6'(cfg_image_pkg::PTR_COUNT - 1)) begin
						phase_next = PH_BLK;
						ld_next = L_SEL;
					end
				end else if ({2'b00, idx_reg} == b_exp - 8'h01) begin
					blk_next = blk_reg + 2'd1;
					ld_next = L_SEL;
				end
			end
			L_SEL: begin
				idx_next = 6'h00;
				if (blk_reg == 2'(cfg_image_pkg::BLK_COUNT)) begin
					ld_next = L_DONE;
				end else if (b_len == b_exp) begin
					pres_next[blk_reg] = 1'b1;
					ld_next = L_REQ;
				end else begin
					// Absent or malformed: keep hardware defaults
					err_next = err_reg | (b_len != 8'h00);
					blk_next = blk_reg + 2'd1;
				end
			end
			L_DONE: begin
				done_next = 1'b1;
				if (sw_reload) begin
					ld_next = L_IDLE;
				end
			end
			default: ld_next = L_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ld_reg <= L_IDLE;
			phase_reg <= PH_FLAGS;
			idx_reg <= 6'h00;
			blk_reg <= 2'd0;
			ptr_reg <= '{default: 8'h00};
			flags_reg <= cfg_image_pkg::PME_FLAGS_RST;
			pres_reg <= 3'b000;
			err_reg <= 1'b0;
			done_reg <= 1'b0;
			ee_req_reg <= 1'b0;
			ee_addr_reg <= '0;
		end else begin
			ld_reg <= ld_next;
			phase_reg <= phase_next;
			idx_reg <= idx_next;
			blk_reg <= blk_next;
			ptr_reg <= ptr_next;
			flags_reg <= flags_next;
			pres_reg <= pres_next;
			err_reg <= err_next;
			done_reg <= done_next;
			ee_req_reg <= ee_req_next;
			ee_addr_reg <= ee_addr_next;
		end
	end

	cfg_byte_mem #(
		.DW(8),
		.DEPTH(cfg_image_pkg::STORE_DEPTH),
		.AW(6)
	) u_store (
		.sys_clk(sys_clk),
		.we(mem_we),
		.waddr(mem_waddr),
		.wdata(ee_rd_data),
		.raddr(mem_raddr),
		.rdata(mem_rdata)
	);

	// Store index straight from the bus; the memory is read one cycle early
	assign mem_raddr = avs_address[7:2];

	// Bus slave: decode one cycle after the request, answer the next
	always_comb begin
		bus_next = bus_reg;
		rd_next = rd_reg;
		wait_next = 1'b1;
		sw_clear = 1'b0;
		sw_reload = 1'b0;
		case (bus_reg)
			B_IDLE: begin
				if (avs_read || avs_write) begin
					bus_next = B_DEC;
				end
			end
			B_DEC: begin
				rd_next = 32'h0000_0000;
				if (avs_write && avs_address == cfg_image_pkg::CTRL_ADDR
				    && avs_byteenable[0]) begin
					sw_clear = avs_writedata[cfg_image_pkg::CTRL_CLR_BIT];
					sw_reload = avs_writedata[cfg_image_pkg::CTRL_RELOAD_BIT];
				end
				if (avs_read) begin
					if (avs_address == cfg_image_pkg::STATUS_ADDR) begin
						rd_next[cfg_image_pkg::ST_DONE_BIT] = done_reg;
						rd_next[cfg_image_pkg::ST_ERR_BIT] = err_reg;
						rd_next[cfg_image_pkg::ST_WAKE_BIT] = wake_active;
						rd_next[cfg_image_pkg::ST_PRES_LSB +: 3] = pres_reg;
					end else if (avs_address == cfg_image_pkg::FLAGS_ADDR) begin
						rd_next[7:0] = flags_reg;
					end else if (avs_address[11:8] == cfg_image_pkg::PTR_PAGE
					    && avs_address[7:2] < 6'(cfg_image_pkg::PTR_COUNT)) begin
						// BOS and descriptor entries served as stored
						rd_next[7:0] = ptr_reg[avs_address[6:2]];
					end else if (avs_address[11:8] == cfg_image_pkg::STORE_PAGE
					    && avs_address[7:2] < 6'(cfg_image_pkg::STORE_DEPTH)) begin
						// Absent block reads its default of zero
						if ((mem_raddr < cfg_image_pkg::LTM_BASE && pres_reg[0])
						    || (mem_raddr >= cfg_image_pkg::LTM_BASE
						    && mem_raddr < cfg_image_pkg::TB_BASE && pres_reg[1])
						    || (mem_raddr >= cfg_image_pkg::TB_BASE
						    && pres_reg[2])) begin
							rd_next[7:0] = mem_rdata;
						end
					end
				end
				wait_next = 1'b0;
				bus_next = B_ACK;
			end
			B_ACK: bus_next = B_IDLE;
			default: bus_next = B_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			bus_reg <= B_IDLE;
			rd_reg <= 32'h0000_0000;
			wait_reg <= 1'b1;
		end else begin
			bus_reg <= bus_next;
			rd_reg <= rd_next;
			wait_reg <= wait_next;
		end
	end

	// Wake events count only once the image is in and the enable is set
	assign ev = (gpio_wake_event | packet_event | wake_frame_filter_match
		| exact_destination_match | link_change_event)
		& flags_reg[cfg_image_pkg::PME_EN_BIT] & done_reg;
	assign wake_active = flags_reg[cfg_image_pkg::PME_EN_BIT]
		& (flags_reg[cfg_image_pkg::PME_PULSE_BIT] ? (cnt_reg != '0)
		: lvl_reg);
	assign pin_level = wake_active ? flags_reg[cfg_image_pkg::PME_POL_BIT]
		: ~flags_reg[cfg_image_pkg::PME_POL_BIT];

	// Level latch and pulse timer; a new event never reloads the timer
	always_comb begin
		lvl_next = lvl_reg;
		cnt_next = cnt_reg;
		if (ev && !flags_reg[cfg_image_pkg::PME_PULSE_BIT]) begin
			lvl_next = 1'b1; // Set wins over a clear in the same cycle
		end else if (sw_clear || sw_reload) begin
			lvl_next = 1'b0;
		end
		if (sw_reload) begin
			cnt_next = '0;
		end else if (cnt_reg != '0) begin
			cnt_next = cnt_reg - CW'(1);
		end else if (ev && flags_reg[cfg_image_pkg::PME_PULSE_BIT]) begin
			cnt_next = flags_reg[cfg_image_pkg::PME_LONG_BIT]
				? CW'(PULSE_LONG_CYC) : CW'(PULSE_SHORT_CYC);
		end
		// Pin stays undriven until the image is loaded and enabled
		pin_o_next = 1'b0;
		pin_oe_next = 1'b0;
		if (done_reg && flags_reg[cfg_image_pkg::PME_EN_BIT]) begin
			if (flags_reg[cfg_image_pkg::PME_PP_BIT]) begin
				pin_o_next = pin_level;
				pin_oe_next = 1'b1;
			end else begin
				pin_oe_next = ~pin_level; // Open drain only pulls low
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			lvl_reg <= 1'b0;
			cnt_reg <= '0;
			pin_o_reg <= 1'b0;
			pin_oe_reg <= 1'b0;
		end else begin
			lvl_reg <= lvl_next;
			cnt_reg <= cnt_next;
			pin_o_reg <= pin_o_next;
			pin_oe_reg <= pin_oe_next;
		end
	end

	assign avs_readdata = rd_reg;
	assign avs_waitrequest = wait_reg;
	assign ee_rd_req = ee_req_reg;
	assign ee_addr = ee_addr_reg;
	assign wake_request_pin_o = pin_o_reg;
	assign wake_request_pin_oe = pin_oe_reg;
	assign config_done = done_reg;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	sequence s_pulse_start;
		ev && flags_reg[cfg_image_pkg::PME_PULSE_BIT] && cnt_reg == '0
			&& !sw_reload;
	endsequence
	sequence s_blk_req;
		$rose(ee_req_reg) && phase_reg == PH_BLK;
	endsequence

	property p_wf_map;
		mem_we && blk_reg == 2'd0 |-> mem_waddr == idx_reg[5:0];
	endproperty
	a_wf_map: assert property (p_wf_map)
		else $error("filter byte misplaced");
	property p_ptr_order;
		$rose(ee_req_reg) && phase_reg == PH_PTR |->
			ee_addr_reg == EE_AW'(cfg_image_pkg::PTR_FIRST_OFS) + EE_AW'(idx_reg);
	endproperty
	a_ptr_order: assert property (p_ptr_order)
		else $error("table read order");
	property p_disabled;
		!flags_reg[cfg_image_pkg::PME_EN_BIT] |=> !pin_oe_reg;
	endproperty
	a_disabled: assert property (p_disabled)
		else $error("pin driven off");
	// Latch holds on; only a software clear or reload may drop it later
	property p_level;
		ev && !flags_reg[cfg_image_pkg::PME_PULSE_BIT] |=> lvl_reg
			##1 (lvl_reg || $past(sw_clear || sw_reload));
	endproperty
	a_level: assert property (p_level)
		else $error("level not held");
	property p_pulse_len;
		s_pulse_start |=> cnt_reg == (flags_reg[cfg_image_pkg::PME_LONG_BIT]
			? CW'(PULSE_LONG_CYC) : CW'(PULSE_SHORT_CYC));
	endproperty
	a_pulse_len: assert property (p_pulse_len)
		else $error("pulse length");
	property p_no_restart;
		cnt_reg > CW'(1) && !sw_reload |=> cnt_reg == $past(cnt_reg) - CW'(1);
	endproperty
	a_no_restart: assert property (p_no_restart)
		else $error("pulse restarted");
	property p_polarity;
		done_reg && wake_active && flags_reg[cfg_image_pkg::PME_PP_BIT] |=>
			pin_oe_reg && pin_o_reg == flags_reg[cfg_image_pkg::PME_POL_BIT];
	endproperty
	a_polarity: assert property (p_polarity)
		else $error("pin polarity");
	property p_open_drain;
		!flags_reg[cfg_image_pkg::PME_PP_BIT] |=> !pin_o_reg;
	endproperty
	a_open_drain: assert property (p_open_drain)
		else $error("drain drove high");
	property p_word_addr;
		s_blk_req |-> ee_addr_reg == EE_AW'({b_ptr, 1'b0}) + EE_AW'(idx_reg);
	endproperty
	a_word_addr: assert property (p_word_addr)
		else $error("word offset");
	// Next block may be selected at once, but no read is issued meanwhile
	property p_absent;
		ld_reg == L_SEL && blk_reg != 2'd3 && b_len == 8'h00 |=>
			ld_reg == L_SEL && !ee_req_reg ##1 !ee_req_reg;
	endproperty
	a_absent: assert property (p_absent)
		else $error("absent block read");
	property p_release;
		!done_reg |=> !pin_oe_reg;
	endproperty
	a_release: assert property (p_release)
		else $error("early wake pin");
endmodule
`default_nettype wire

// ### bench/ee_image_model.sv
// Behavioural configuration memory that answers the loader's byte reads
`timescale 1ns/1ps
`default_nettype none
module ee_image_model #(
	parameter int AW = 10
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic slow,
	input wire logic ee_rd_req,
	input wire logic [AW-1:0] ee_addr,
	output logic [7:0] ee_rd_data,
	output logic ee_rd_valid
);
	logic [7:0] mem [0:(1<<AW)-1];
	logic [AW-1:0] addr_reg;
	logic busy;
	logic [3:0] cnt;
	// Image: block bytes carry an address pattern, then the pointer table
	initial begin
		for (int i = 0; i < (1 << AW); i++) begin
			mem[i] = i[7:0] ^ 8'h5a;
		end
		for (int i = 8'h30; i < 8'h48; i++) begin
			mem[i] = i[0] ? 8'h12 : 8'h60 + i[7:0];
		end
		mem[8'h09] = 8'h00;
		mem[8'h3d] = 8'h14;
		mem[8'h3e] = 8'h80;
		mem[8'h3f] = 8'h18;
		mem[8'h40] = 8'h90;
		mem[8'h41] = 8'h04;
		mem[8'h42] = 8'ha0;
		mem[8'h43] = 8'h00;
		mem[8'h44] = 8'h02;
		mem[8'h45] = 8'h00;
		mem[8'h46] = 8'h08;
		mem[8'h47] = 8'hb0;
		for (int i = 8'h50; i < 8'h58; i++) begin
			mem[i] = 8'h00;
		end
	end
	// One outstanding read; idle data flips every cycle so stale bytes show
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			busy <= 1'b0;
			cnt <= 4'h0;
			addr_reg <= '0;
			ee_rd_valid <= 1'b0;
			ee_rd_data <= 8'h00;
		end else begin
			ee_rd_valid <= 1'b0;
			ee_rd_data <= ~ee_rd_data;
			if (ee_rd_req) begin
				busy <= 1'b1;
				addr_reg <= ee_addr;
				cnt <= slow ? 4'h6 : 4'h0;
			end else if (busy && cnt != 4'h0) begin
				cnt <= cnt - 4'h1;
			end else if (busy) begin
				busy <= 1'b0;
				ee_rd_valid <= 1'b1;
				ee_rd_data <= mem[addr_reg];
			end
		end
	end
endmodule
`default_nettype wire

// ### bench/eeprom_config_image_pme_tb.sv
// Self-checking bench for the image loader and wake request pin
`timescale 1ns/1ps
`default_nettype none
module eeprom_config_image_pme_tb;
	localparam int SHORT = 20;
	localparam int LONG = 50;
	logic sys_clk;
	logic rst_n;
	logic [11:0] avs_address;
	logic avs_read;
	logic avs_write;
	logic [31:0] avs_writedata;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic ee_rd_req;
	logic [9:0] ee_addr;
	logic [7:0] ee_rd_data;
	logic ee_rd_valid;
	logic [4:0] ev;
	logic pin_o;
	logic pin_oe;
	logic config_done;
	logic slow;
	logic mon_on;
	int n_errors;
	int n_tests;
	int mon_idx;
	logic [31:0] q;
	// Pull-up sets the wake line whenever nobody drives it
	wire logic pin_lvl = pin_oe ? pin_o : 1'b1;

	eeprom_config_image_pme #(
		.EE_AW(10),
		.PULSE_SHORT_CYC(SHORT),
		.PULSE_LONG_CYC(LONG)
	) uut (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.avs_address(avs_address),
		.avs_read(avs_read),
		.avs_write(avs_write),
		.avs_writedata(avs_writedata),
		.avs_byteenable(4'hf),
		.avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest),
		.ee_rd_req(ee_rd_req),
		.ee_addr(ee_addr),
		.ee_rd_data(ee_rd_data),
		.ee_rd_valid(ee_rd_valid),
		.gpio_wake_event(ev[0]),
		.packet_event(ev[1]),
		.wake_frame_filter_match(ev[2]),
		.exact_destination_match(ev[3]),
		.link_change_event(ev[4]),
		.wake_request_pin_o(pin_o),
		.wake_request_pin_oe(pin_oe),
		.config_done(config_done)
	);
	ee_image_model #(.AW(10)) u_mem (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.slow(slow),
		.ee_rd_req(ee_rd_req),
		.ee_addr(ee_addr),
		.ee_rd_data(ee_rd_data),
		.ee_rd_valid(ee_rd_valid)
	);

	// Clock
	initial begin
		sys_clk = 1'b0;
		forever #(cfg_image_pkg::CLK_PERIOD_NS / 2) sys_clk = ~sys_clk;
	end

	task automatic final_report;
		$display("errors %0d, checks %0d", n_errors, n_tests);
		if (n_errors == 0 && n_tests > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// One Avalon access; an idle cycle after it keeps strobes from toggling
	// twice in one time step
	task automatic bus(input logic wr, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= !wr;
		avs_write <= wr;
		@(posedge sys_clk);
		while (avs_waitrequest !== 1'b0 && n < 50) begin
			@(posedge sys_clk);
			n++;
		end
		q = avs_readdata;
		if (n == 50) n_errors++;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge sys_clk);
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(q, e);
	endtask

	task automatic wait_done;
		int n;
		n = 0;
		while (config_done !== 1'b1 && n < 3000) begin
			@(posedge sys_clk);
			n++;
		end
		chk({31'h0, config_done}, 32'h1);
	endtask

	// Byte address of the i-th image read: flags, table, then the blocks
	function automatic logic [31:0] exp_addr(input int i);
		if (i == 0) return 32'h09;
		if (i < 25) return 32'h2f + i;
		if (i < 45) return 32'h100 + i - 25;
		if (i < 69) return 32'h120 + i - 45;
		return 32'h140 + i - 69;
	endfunction

	// Order of image reads during the first load
	always @(posedge sys_clk) begin
		if (mon_on && ee_rd_req === 1'b1) begin
			chk({22'h0, ee_addr}, exp_addr(mon_idx));
			mon_idx <= mon_idx + 1;
		end
	end

	task automatic reload(input logic [7:0] f);
		int n;
		n = 0;
		u_mem.mem[9] = f;
		bus(1'b1, cfg_image_pkg::CTRL_ADDR,
			32'h1 << cfg_image_pkg::CTRL_RELOAD_BIT);
		while (config_done !== 1'b0 && n < 8) begin
			@(posedge sys_clk);
			n++;
		end
		chk({31'h0, config_done}, 32'h0);
		wait_done();
	endtask

	// Load a flag byte, then raise one wake source and watch the line
	task automatic pme_case(input logic [7:0] f, input int s);
		int n;
		reload(f);
		rd(cfg_image_pkg::FLAGS_ADDR, {24'h0, f});
		repeat (3) @(posedge sys_clk);
		if (f[7]) chk({31'h0, pin_lvl}, {31'h0, ~f[4]});
		if (!f[7]) begin
			fire(s);
			repeat (3) @(posedge sys_clk);
			chk({31'h0, pin_oe}, 32'h0);
		end else if (!f[6]) begin
			fire(s);
			repeat (20) @(posedge sys_clk);
			chk({31'h0, pin_lvl}, {31'h0, f[4]});
			rd(cfg_image_pkg::STATUS_ADDR, (32'h7 << cfg_image_pkg::ST_PRES_LSB)
				| (32'h1 << cfg_image_pkg::ST_WAKE_BIT) | 32'h1);
			bus(1'b1, cfg_image_pkg::CTRL_ADDR, 32'h1);
			repeat (3) @(posedge sys_clk);
		end else begin
			n = 0;
			ev[s] <= 1'b1;
			for (int k = 0; k < 200; k++) begin
				@(posedge sys_clk);
				ev[s] <= (k == 8);
				if (pin_lvl === f[4]) n++;
			end
			chk(n, f[5] ? LONG : SHORT);
		end
		if (f[7]) chk({31'h0, pin_lvl}, {31'h0, ~f[4]});
		if (f[7]) chk({31'h0, pin_oe}, {31'h0, f[3] | f[4]});
	endtask

	task automatic fire(input int s);
		ev[s] <= 1'b1;
		@(posedge sys_clk);
		ev[s] <= 1'b0;
		@(posedge sys_clk);
	endtask

	// Hang guard, well beyond seven loads and the pulse runs
	initial begin
		#(cfg_image_pkg::CLK_PERIOD_NS * 60000);
		n_errors++;
		final_report();
	end

	// Main sequence: slow first load, table and store, then reloads
	initial begin
		rst_n = 1'b0;
		avs_address = 12'h000;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		ev = 5'h00;
		slow = 1'b1;
		mon_on = 1'b1;
		mon_idx = 0;
		n_errors = 0;
		n_tests = 0;
		repeat (5) @(posedge sys_clk);
		chk({31'h0, avs_waitrequest}, 32'h1);
		chk({31'h0, pin_oe}, 32'h0);
		rst_n <= 1'b1;
		@(posedge sys_clk);
		wait_done();
		mon_on = 1'b0;
		chk(mon_idx, 73);
		rd(cfg_image_pkg::STATUS_ADDR,
			(32'h7 << cfg_image_pkg::ST_PRES_LSB) | 32'h1);
		for (int i = 0; i < 24; i++) begin
			rd({cfg_image_pkg::PTR_PAGE, 8'(4 * i)},
				{24'h0, u_mem.mem[8'h30 + i]});
		end
		for (int j = 0; j < 48; j++) begin
			rd({cfg_image_pkg::STORE_PAGE, 8'(4 * j)},
				{24'h0, u_mem.mem[exp_addr(25 + j)]});
		end
		rd(12'hffc, 32'h0);
		// Absent timer block and a bad test bus length, prompt memory
		slow <= 1'b0;
		u_mem.mem[8'h3f] = 8'h00;
		u_mem.mem[8'h41] = 8'h05;
		reload(8'h00);
		rd(cfg_image_pkg::STATUS_ADDR, (32'h1 << cfg_image_pkg::ST_PRES_LSB)
			| (32'h1 << cfg_image_pkg::ST_ERR_BIT) | 32'h1);
		rd({cfg_image_pkg::STORE_PAGE, 8'h50}, 32'h0);
		rd({cfg_image_pkg::STORE_PAGE, 8'hb0}, 32'h0);
		u_mem.mem[8'h3f] = 8'h18;
		u_mem.mem[8'h41] = 8'h04;
		pme_case(8'h78, 0);
		pme_case(8'h98, 1);
		pme_case(8'h90, 2);
		pme_case(8'hc8, 3);
		pme_case(8'hf0, 4);
		final_report();
	end
endmodule
`default_nettype wire
